//--- rtl/pio_pkg.sv
// Shared constants and types of the parallel port block
package pio_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PIN_W  = 33;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SINGLE   = 8'h00;
    localparam logic [7:0] OFF_SIX      = 8'h01;
    localparam logic [7:0] OFF_DIRA     = 8'h02;
    localparam logic [7:0] OFF_ANALOG   = 8'h03;
    localparam logic [7:0] OFF_DISPLAY  = 8'h04;
    localparam logic [7:0] OFF_SYNC     = 8'h05;
    localparam logic [7:0] OFF_DIRA_DIR = 8'h06;
    localparam logic [7:0] OFF_DISP_DIR = 8'h07;
    localparam logic [7:0] OFF_DISP_SEL = 8'h08;
    localparam logic [7:0] OFF_CONV     = 8'h09;
    localparam logic [7:0] OFF_EIRQ     = 8'h0a;

    // ------------------------------------------------------------
    // Reset values and fill patterns
    // ------------------------------------------------------------
    localparam logic [7:0] LATCH_RST = 8'hff;
    localparam logic [7:0] DIR_RST   = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [3:0] SEL_RST   = 4'h0;
    localparam logic [7:0] UNDEF_VAL = 8'h00;
    localparam logic [7:0] UNMAP_VAL = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned AIN_DIS_BIT  = 4;
    localparam int unsigned CHAN_LSB     = 0;
    localparam int unsigned CHAN_W       = 4;
    localparam int unsigned EXTERNAL_INTERRUPT_ZERO_EN_BIT  = 6;
    localparam int unsigned OSD_LSB      = 4;
    localparam logic [3:0]  CHAN_RST_PIN = 4'h3;
    localparam int unsigned CHAN_NUM     = 16;
    localparam int unsigned DISP_CHAN0   = 8;

    // ------------------------------------------------------------
    // Pin vector slices: {sync, display, analog, dira, six, single}
    // ------------------------------------------------------------
    localparam int unsigned PIN_SINGLE  = 0;
    localparam int unsigned PIN_SIX     = 1;
    localparam int unsigned PIN_DIRA    = 7;
    localparam int unsigned PIN_ANALOG  = 15;
    localparam int unsigned PIN_DISPLAY = 23;
    localparam int unsigned PIN_SYNC    = 31;

    // ------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       rd_latch;
    } pio_req_t;

endpackage

//--- rtl/pio_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module pio_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_r;

    // First stage feeds only the second; pins idle high like the latches
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '1;
            sync_o <= '1;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

//--- rtl/pio_ports.sv
// Six parallel I/O ports with latches, direction and secondary-function set-up
//
// Function
// - Each bit has an output latch; input reads return live pin level.
// - Pin data is sampled in the read strobe cycle.
// - Latch and pin change at the edge closing the write cycle.
// - Ports without direction: bit-op reads latch, other reads read pins.
// - Single-bit port latch resets to one; pin also an interrupt source.
// - Falling edge on single-bit pin sets interrupt, even when driven out.
// - Single-bit port reads give undefined bits 7 to 1.
// - Six-bit port latches reset to ones.
// - Direction port A bit: 0 input, 1 output.
// - Reset clears port A direction and sets its latches to one.
// - Reset sets analog port latches; clears disable and channel fields.
// - Analog pin 0 is I/O or interrupt zero by enable bit 6.
// - Display port has per-bit direction; reset clears it, latches one.
// - Display port writes always update latch regardless of direction.
// - Sync port latches reset to one; pins feed sync inputs.
// - Sync port reads give undefined bits 7 to 2.
// - Mixed-direction bit ops read input pins and rewrite their latches.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module pio_ports (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 arst_n_i,
    // CPU register port
    input  wire pio_pkg::pio_req_t    req_i,
    output logic [7:0]                rdata_o,
    // Pins: level in, level out, drive enable (low drives)
    input  wire logic [32:0]          pin_i,
    output logic [32:0]               pin_o,
    output logic [32:0]               pin_oe_n_o,
    // On-screen display colour and blanking sources
    input  wire logic [3:0]           osd_i,
    // Secondary-function outputs
    output logic                      single_irq_o,
    output logic                      ext_irq_zero_o,
    output logic                      vertical_sync_in_o,
    output logic                      horizontal_sync_in_o,
    output logic [15:0]               analog_chan_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic        single_r;
    logic [5:0]  six_r;
    logic [7:0]  dira_r;
    logic [7:0]  dira_dir_r;
    logic [7:0]  analog_r;
    logic [7:0]  disp_r;
    logic [7:0]  disp_dir_r;
    logic [3:0]  disp_sel_r;
    logic [1:0]  sync_r;
    logic [7:0]  conv_r;
    logic [7:0]  eirq_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        single_prev_r;
    logic [32:0] pin_s;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Select of a mapped offset for write decode
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Ports without direction: latch for bit ops, pins otherwise
    function automatic logic [7:0] plain_rd(input logic       lat_sel,
                                            input logic [7:0] lat,
                                            input logic [7:0] pin);
        plain_rd = lat_sel ? lat : pin;
    endfunction

    // Direction ports: outputs read latch, inputs read pin
    function automatic logic [7:0] dir_rd(input logic [7:0] dir,
                                          input logic [7:0] lat,
                                          input logic [7:0] pin);
        dir_rd = (dir & lat) | (~dir & pin);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pio_sync #(
        .W (pio_pkg::PIN_W)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   (pin_i),
        .sync_o    (pin_s)
    );

    // Port slices of the synchronised pins
    logic       pin_single;
    logic [5:0] pin_six;
    logic [7:0] pin_dira;
    logic [7:0] pin_analog;
    logic [7:0] pin_disp;
    logic [1:0] pin_sync;

    assign pin_single = pin_s[pio_pkg::PIN_SINGLE];
    assign pin_six    = pin_s[pio_pkg::PIN_SIX +: 6];
    assign pin_dira   = pin_s[pio_pkg::PIN_DIRA +: 8];
    assign pin_analog = pin_s[pio_pkg::PIN_ANALOG +: 8];
    assign pin_disp   = pin_s[pio_pkg::PIN_DISPLAY +: 8];
    assign pin_sync   = pin_s[pio_pkg::PIN_SYNC +: 2];

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    logic wr;

    assign wr = req_i.wr;

    // Single-bit and six-bit latches preset high
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            single_r <= pio_pkg::LATCH_RST[0];
            six_r    <= pio_pkg::LATCH_RST[5:0];
        end else if (wr && hit(req_i.addr, pio_pkg::OFF_SINGLE)) begin
            single_r <= req_i.wdata[0];
        end else if (wr && hit(req_i.addr, pio_pkg::OFF_SIX)) begin
            six_r <= req_i.wdata[5:0];
        end
    end

    // Port A latch and direction
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dira_r     <= pio_pkg::LATCH_RST;
            dira_dir_r <= pio_pkg::DIR_RST;
        end else begin
            // Whole byte is rewritten, inputs included
            if (wr && hit(req_i.addr, pio_pkg::OFF_DIRA))
                dira_r <= req_i.wdata;
            if (wr && hit(req_i.addr, pio_pkg::OFF_DIRA_DIR))
                dira_dir_r <= req_i.wdata;
        end
    end

    // Analog-shared port latch
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            analog_r <= pio_pkg::LATCH_RST;
        end else if (wr && hit(req_i.addr, pio_pkg::OFF_ANALOG)) begin
            analog_r <= req_i.wdata;
        end
    end

    // Display port: latch loads whatever the direction is
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            disp_r     <= pio_pkg::LATCH_RST;
            disp_dir_r <= pio_pkg::DIR_RST;
            disp_sel_r <= pio_pkg::SEL_RST;
        end else begin
            if (wr && hit(req_i.addr, pio_pkg::OFF_DISPLAY))
                disp_r <= req_i.wdata;
            if (wr && hit(req_i.addr, pio_pkg::OFF_DISP_DIR))
                disp_dir_r <= req_i.wdata;
            if (wr && hit(req_i.addr, pio_pkg::OFF_DISP_SEL))
                disp_sel_r <= req_i.wdata[3:0];
        end
    end

    // Sync port latch
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_r <= pio_pkg::LATCH_RST[1:0];
        end else if (wr && hit(req_i.addr, pio_pkg::OFF_SYNC)) begin
            sync_r <= req_i.wdata[1:0];
        end
    end

    // Converter and interrupt control
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_r <= pio_pkg::CTRL_RST;
            eirq_r <= pio_pkg::CTRL_RST;
        end else begin
            if (wr && hit(req_i.addr, pio_pkg::OFF_CONV))
                conv_r <= req_i.wdata;
            if (wr && hit(req_i.addr, pio_pkg::OFF_EIRQ))
                eirq_r <= req_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Pin levels are taken in the strobe cycle itself; no latch is kept
    always_comb begin
        rdata_nxt = pio_pkg::UNMAP_VAL;
        unique case (req_i.addr)
            pio_pkg::OFF_SINGLE: begin
                rdata_nxt = {pio_pkg::UNDEF_VAL[7:1],
                             req_i.rd_latch ? single_r : pin_single};
            end
            pio_pkg::OFF_SIX: begin
                rdata_nxt = plain_rd(req_i.rd_latch,
                                     {2'h0, six_r},
                                     {2'h0, pin_six});
            end
            pio_pkg::OFF_DIRA: begin
                rdata_nxt = dir_rd(dira_dir_r, dira_r, pin_dira);
            end
            pio_pkg::OFF_ANALOG: begin
                rdata_nxt = plain_rd(req_i.rd_latch, analog_r,
                                     pin_analog);
            end
            pio_pkg::OFF_DISPLAY: begin
                rdata_nxt = dir_rd(disp_dir_r, disp_r, pin_disp);
            end
            pio_pkg::OFF_SYNC: begin
                rdata_nxt = {pio_pkg::UNDEF_VAL[7:2],
                             req_i.rd_latch ? sync_r : pin_sync};
            end
            pio_pkg::OFF_DIRA_DIR: rdata_nxt = dira_dir_r;
            pio_pkg::OFF_DISP_DIR: rdata_nxt = disp_dir_r;
            pio_pkg::OFF_DISP_SEL: rdata_nxt = {4'h0, disp_sel_r};
            pio_pkg::OFF_CONV:     rdata_nxt = conv_r;
            pio_pkg::OFF_EIRQ:     rdata_nxt = eirq_r;
            default:               rdata_nxt = pio_pkg::UNMAP_VAL;
        endcase
    end

    // Data stands only in the cycle after the strobe; never a wait
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= pio_pkg::UNMAP_VAL;
        end else begin
            rdata_r <= req_i.rd ? rdata_nxt : pio_pkg::UNMAP_VAL;
        end
    end

    assign rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic [7:0] disp_out;

    // Selected upper display pins carry the colour sources
    assign disp_out = {disp_sel_r[3:0] & osd_i | ~disp_sel_r[3:0] & disp_r[7:4],
                       disp_r[3:0]};

    // Plain ports pull low only; a latch at one leaves the pin as input
    assign pin_o = {sync_r, disp_out, analog_r, dira_r, six_r,
                    single_r};
    assign pin_oe_n_o = {sync_r,
                         ~disp_dir_r,
                         analog_r,
                         ~dira_dir_r,
                         six_r,
                         single_r};

    // ------------------------------------------------------------
    // Secondary functions
    // ------------------------------------------------------------

    // Edge on the single-bit pin; the pin follows a driven output too
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            single_prev_r <= 1'b1;
        end else begin
            single_prev_r <= pin_single;
        end
    end

    assign single_irq_o = single_prev_r & ~pin_single;

    // Interrupt zero only when enabled; after reset the pin is plain I/O
    assign ext_irq_zero_o = eirq_r[pio_pkg::EXTERNAL_INTERRUPT_ZERO_EN_BIT] & pin_analog[0];

    assign vertical_sync_in_o   = pin_sync[0];
    assign horizontal_sync_in_o = pin_sync[1];

    // Channel zero sits on analog pin 3, so a cleared field picks that pin
    logic [3:0] chan_pin;

    assign chan_pin = 4'(conv_r[pio_pkg::CHAN_LSB +: pio_pkg::CHAN_W] + pio_pkg::CHAN_RST_PIN);

    // One-hot analog channel; reset value selects analog pin 3
    always_comb begin
        analog_chan_o = 16'h0000;
        if (!conv_r[pio_pkg::AIN_DIS_BIT])
            analog_chan_o[chan_pin] = 1'b1;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_single_rst_one: assert property (
        @(posedge ref_clk_i) $rose(arst_n_i) |-> single_r == 1'b1 && pin_oe_n_o[0])
        else $error("single-bit latch not one after reset");

    a_write_latch: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.wr && req_i.addr == pio_pkg::OFF_ANALOG
        |=> pin_o[pio_pkg::PIN_ANALOG +: 8] == $past(req_i.wdata))
        else $error("analog port pin did not follow write");

    a_read_one_cycle: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !req_i.rd |=> rdata_o == pio_pkg::UNMAP_VAL)
        else $error("read data outside its cycle");

    a_plain_read_pin: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.rd && !req_i.rd_latch && req_i.addr == pio_pkg::OFF_ANALOG
        |=> rdata_o == $past(pin_analog))
        else $error("pin read returned wrong data");

    a_latch_read: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.rd && req_i.rd_latch && req_i.addr == pio_pkg::OFF_SIX
        |=> rdata_o == {2'h0, $past(six_r)})
        else $error("latch read returned wrong data");

    a_undef_bits: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.rd && req_i.addr == pio_pkg::OFF_SINGLE
        |=> rdata_o[7:1] == pio_pkg::UNDEF_VAL[7:1])
        else $error("single-bit upper bits wrong");

    a_dir_drive: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.wr && req_i.addr == pio_pkg::OFF_DIRA_DIR
        |=> pin_oe_n_o[pio_pkg::PIN_DIRA +: 8] == ~$past(req_i.wdata))
        else $error("port A drive not set by direction");

    a_disp_latch_any: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.wr && req_i.addr == pio_pkg::OFF_DISPLAY
        |=> disp_r == $past(req_i.wdata))
        else $error("display latch not loaded");

    a_fall_irq: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        $fell(pin_single) |-> single_irq_o ##1 !single_irq_o)
        else $error("single-bit falling edge missed");

    a_external_interrupt_zero_gate: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !eirq_r[pio_pkg::EXTERNAL_INTERRUPT_ZERO_EN_BIT] |-> !ext_irq_zero_o)
        else $error("interrupt zero active while disabled");

    a_analog_rst: assert property (
        @(posedge ref_clk_i) $rose(arst_n_i)
        |-> analog_chan_o[pio_pkg::CHAN_RST_PIN] && analog_r == pio_pkg::LATCH_RST)
        else $error("analog reset set-up wrong");

    a_mixed_read: assert property (
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        req_i.rd && req_i.addr == pio_pkg::OFF_DIRA
        |=> rdata_o == (($past(dira_dir_r) & $past(dira_r))
                        | (~$past(dira_dir_r) & $past(pin_dira))))
        else $error("port A mixed read wrong");

endmodule

//--- tb/pio_pins_model.sv
// Pin-side partner: pull-ups and an outside driver on each pin
`timescale 1ns/100ps
module pio_pins_model (
    // Design side of each pin
    input  wire logic [32:0] dut_pin_i,
    input  wire logic [32:0] dut_oe_n_i,
    // Outside driver set by the bench
    input  wire logic [32:0] ext_drv_i,
    input  wire logic [32:0] ext_val_i,
    // Resolved wire level
    output logic      [32:0] pin_lvl_o
);
    // Design drive wins, then the outside one; a released pin floats up to one
    always_comb begin
        for (int i = 0; i < 33; i++) begin
            pin_lvl_o[i] = !dut_oe_n_i[i] ? dut_pin_i[i] : ext_drv_i[i] ? ext_val_i[i] : 1'b1;
        end
    end
endmodule

//--- tb/tb_pio_ports.sv
// Self-checking bench for the parallel port block
`timescale 1ns/100ps
module tb_pio_ports;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    localparam logic [32:0] PLAIN = 33'h1_807f_807f;
    logic              ref_clk_i = 1'b0;
    logic              arst_n_i  = 1'b0;
    pio_pkg::pio_req_t req_i     = '0;
    logic [3:0]        osd_i     = 4'h0;
    logic [32:0]       ext_drv   = '0;
    logic [32:0]       ext_val   = '0;
    logic [32:0]       pin_i;
    logic [32:0]       pin_o;
    logic [32:0]       pin_oe_n_o;
    logic [7:0]        rdata_o;
    logic [15:0]       analog_chan_o;
    logic              single_irq_o;
    logic              ext_irq_zero_o;
    logic              vsync;
    logic              hsync;
    logic [7:0]        rg [0:10];
    int                error_cnt = 0;
    int                n_tests   = 0;
    int                cyc       = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    pio_ports u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .rdata_o(rdata_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .osd_i(osd_i),
        .single_irq_o(single_irq_o), .ext_irq_zero_o(ext_irq_zero_o), .vertical_sync_in_o(vsync),
        .horizontal_sync_in_o(hsync), .analog_chan_o(analog_chan_o));
    pio_pins_model u_pins (.dut_pin_i(pin_o), .dut_oe_n_i(pin_oe_n_o), .ext_drv_i(ext_drv),
        .ext_val_i(ext_val), .pin_lvl_o(pin_i));

    // ------------------------------------------------------------
    // Model: latch vector, wire levels, read data
    // ------------------------------------------------------------
    function automatic logic [32:0] lat_v();
        return {rg[5][1:0], rg[4], rg[3], rg[2], rg[1][5:0], rg[0][0]};
    endfunction
    function automatic logic [32:0] lvl_v();
        logic [32:0] l;
        logic [32:0] drv;
        l = lat_v();
        drv = (~l & PLAIN) | {2'b0, rg[7], 8'h0, rg[6], 7'h0};
        return (drv & l) | (~drv & ~(ext_drv & ~ext_val));
    endfunction
    function automatic logic [7:0] sl(logic [32:0] v, int a);
        case (a)
            0: return {7'h0, v[0]};
            1: return {2'h0, v[6:1]};
            2: return v[14:7];
            3: return v[22:15];
            4: return v[30:23];
            5: return {6'h0, v[32:31]};
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] exp_rd(int a, bit rl);
        logic [7:0] d;
        d = rg[a == 2 ? 6 : 7];
        if (a > 10) return 8'h00;
        if (a > 5) return rg[a];
        if (a == 2 || a == 4) return (d & sl(lat_v(), a)) | (~d & sl(lvl_v(), a));
        return sl(rl ? lat_v() : lvl_v(), a);
    endfunction

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(int a, logic [7:0] d);
        @(posedge ref_clk_i);
        req_i <= '{a[7:0], d, 1'b1, 1'b0, 1'b0};
        @(posedge ref_clk_i);
        req_i <= '0;
        if (a < 11) rg[a] = d;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(int a, bit rl);
        @(posedge ref_clk_i);
        req_i <= '{a[7:0], 8'h00, 1'b0, 1'b1, rl};
        @(posedge ref_clk_i);
        req_i <= '0;
        #1 chk("rdata_o", {25'h0, exp_rd(a, rl)}, {25'h0, rdata_o});
    endtask
    task automatic chk_pins();
        logic [32:0] l;
        logic [32:0] v;
        l = lat_v();
        v = lvl_v();
        chk("pin_o", l, pin_o);
        chk("pin_oe_n_o", (l & PLAIN) | ~({2'b0, rg[7], 8'h0, rg[6], 7'h0} | PLAIN), pin_oe_n_o);
        chk("analog_chan_o", rg[9][4] ? 33'h0 : 33'h1 << 4'(rg[9][3:0] + pio_pkg::CHAN_RST_PIN),
            {17'h0, analog_chan_o});
        chk("ext_irq_zero_o", {32'h0, v[15] & rg[10][6]}, {32'h0, ext_irq_zero_o});
        chk("sync inputs", {31'h0, v[32:31]}, {31'h0, hsync, vsync});
    endtask
    task automatic irq_cnt(int e);
        int n = 0;
        repeat (8) begin
            @(posedge ref_clk_i);
            #1 if (single_irq_o === 1'b1) n++;
        end
        chk("single_irq_o pulses", 33'(e), 33'(n));
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h0c0f02aa));
        for (int i = 0; i < 11; i++) rg[i] = (i < 6) ? 8'hff : 8'h00;
        repeat (5) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        for (int a = 0; a < 12; a++) rd(a, 1'b1);
        chk_pins();
        $display("test reset done");
        // Random latches, directions, control and outside levels
        for (int k = 0; k < 60; k++) begin
            ext_drv <= 33'({$urandom(), $urandom()});
            ext_val <= 33'({$urandom(), $urandom()});
            wr(k % 6, 8'($urandom()));
            wr(6 + k % 2, 8'($urandom()));
            wr(9, 8'($urandom()) & 8'h1f);
            wr(10, 8'($urandom()) & 8'h40);
            repeat (3) @(posedge ref_clk_i);
            chk_pins();
            for (int a = 0; a < 6; a++) begin
                rd(a, 1'b0);
                rd(a, 1'b1);
            end
        end
        $display("test random done");
        // Falling edge from outside, then from the latch itself
        wr(0, 8'h01);
        ext_drv <= 33'h1;
        ext_val <= 33'h1;
        repeat (4) @(posedge ref_clk_i);
        ext_val <= 33'h0;
        irq_cnt(1);
        ext_drv <= 33'h0;
        repeat (4) @(posedge ref_clk_i);
        wr(0, 8'h00);
        irq_cnt(1);
        $display("test interrupt done");
        // Display colour sources take the upper display pins
        @(posedge ref_clk_i);
        osd_i <= 4'($urandom());
        wr(4, 8'hff);
        wr(8, 8'h0f);
        wr(7, 8'hf0);
        #1 chk("osd pins", {29'h0, osd_i}, {29'h0, pin_o[30:27]});
        $display("test display done");
        // Second reset in mid-run
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        for (int i = 0; i < 11; i++) rg[i] = (i < 6) ? 8'hff : 8'h00;
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        #1 chk_pins();
        rd(9, 1'b0);
        $display("test second reset done");
        stop_test();
    end
endmodule
